// ==== core/tmr2_compare_out.sv ====
// Compare output state: normal actions and modulator set/clear
`timescale 1ns/1ps
module tmr2_compare_out (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] mode_in,
  input wire logic modulator_in,
  input wire logic match_in,
  input wire logic down_in,
  input wire logic [7:0] compare_in,
  output logic level_out
);
  logic level_reg;
  logic level_next;

  // Next level of the compare output on a match; fixed level at zero and full duty in modulator mode
  always_comb begin
    level_next = level_reg;
    if (modulator_in) begin
      if (mode_in[1] && compare_in == tmr2_pkg::COUNT_BOTTOM) begin
        level_next = mode_in[0]; // Zero duty: low, inverted high
      end else if (mode_in[1] && compare_in == tmr2_pkg::COUNT_TOP) begin
        level_next = ~mode_in[0]; // Full duty: high, inverted low
      end else if (mode_in[1] && match_in) begin
        level_next = down_in ^ mode_in[0];
      end
    end else if (match_in) begin
      case (tmr2_pkg::tmr2_mode_e'(mode_in))
        tmr2_pkg::MODE_TOGGLE: level_next = ~level_reg;
        tmr2_pkg::MODE_CLEAR: level_next = 1'b0;
        tmr2_pkg::MODE_SET: level_next = 1'b1;
        default: level_next = level_reg;
      endcase
    end
  end

  // Internal output state; the port latch never touches it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule // tmr2_compare_out

// ==== core/tmr2_pkg.sv ====
// Shared constants of the 8-bit timer with compare and modulator
package tmr2_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h25;
  localparam logic [7:0] ADDR_COUNT = 8'h24;
  localparam logic [7:0] ADDR_COMPARE = 8'h23;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h38;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h39;
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h31;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RESERVED_BIT = 7;
  localparam int CTRL_MODULATOR_BIT = 6;
  localparam int CTRL_MODE_HI_BIT = 5;
  localparam int CTRL_MODE_LO_BIT = 4;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_SEL_HI_BIT = 2;
  localparam int CTRL_SEL_LO_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_COMPARE_BIT = 1;
  localparam int PORT_LATCH_BIT = 0;
  localparam int PORT_DIR_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h7f;

  // ----------------------------------------------------------------
  // Prescaler: terminal masks for divide by 8, 32, 64, 128, 256, 1024
  // ----------------------------------------------------------------
  localparam int PRE_WIDTH = 10;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_32 = 10'h01f;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_128 = 10'h07f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  // Clock select codes
  typedef enum logic [2:0] {
    SEL_STOP = 3'b000,
    SEL_DIV1 = 3'b001,
    SEL_DIV8 = 3'b010,
    SEL_DIV32 = 3'b011,
    SEL_DIV64 = 3'b100,
    SEL_DIV128 = 3'b101,
    SEL_DIV256 = 3'b110,
    SEL_DIV1024 = 3'b111
  } tmr2_sel_e;

  // Compare output modes
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_TOGGLE = 2'b01,
    MODE_CLEAR = 2'b10,
    MODE_SET = 2'b11
  } tmr2_mode_e;
endpackage

// ==== core/tmr2_prescaler.sv ====
// Clock select prescaler producing the timer count enable
`timescale 1ns/1ps
module tmr2_prescaler #(
  parameter int WIDTH = tmr2_pkg::PRE_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] clock_sel_in,
  output logic tick_out
);
  logic [WIDTH-1:0] pre_reg;

  // Terminal mask of the divider chosen by a select code
  function automatic logic [WIDTH-1:0] sel_mask(input logic [2:0] sel);
    case (tmr2_pkg::tmr2_sel_e'(sel))
      tmr2_pkg::SEL_DIV8: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_8);
      tmr2_pkg::SEL_DIV32: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_32);
      tmr2_pkg::SEL_DIV64: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_64);
      tmr2_pkg::SEL_DIV128: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_128);
      tmr2_pkg::SEL_DIV256: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_256);
      tmr2_pkg::SEL_DIV1024: sel_mask = WIDTH'(tmr2_pkg::PRE_MASK_1024);
      default: sel_mask = '0;
    endcase
  endfunction

  // Free-running divide chain from the system clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // One-cycle enable; stop gives none, divide by one gives every cycle
  always_comb begin
    if (clock_sel_in == tmr2_pkg::SEL_STOP) begin
      tick_out = 1'b0;
    end else begin
      tick_out = (pre_reg & sel_mask(clock_sel_in)) ==
                 sel_mask(clock_sel_in);
    end
  end
endmodule // tmr2_prescaler

// ==== core/tmr2_timer.sv ====
// 8-bit timer with prescaler, compare match and centred modulator
`timescale 1ns/1ps

// Notes on behaviour
// - Select 000 stops; 001 undivided; others divide by 8 to 1024.
// - Control bit 7 is reserved, ignores writes and reads zero.
// - Control bit 6 switches into modulator mode; clearing restores.
// - Normal mode codes: none, toggle, clear, set on a match.
// - Compare output drives the pin only with direction bit set.
// - Port latch writes never preset the compare output state.
// - Bit 3 clears the counter the cycle after a match.
// - Divide by one with clear shows the compare value once, then 0.
// - The clear bit has no effect in modulator mode.
// - Counter is read/write; resumes from the written value.
// - Compare register is compared with the counter continuously.
// - Only counting into the value matches; writes never do.
// - Match flag sets in the cycle after the match.
// - Flags in a shared flag register, gated by a shared mask.
// - Modulator mode is a glitch-free centred 8-bit modulator.
// - Modulator counts 0 up to 255 and back down, period 510.
// - Modulator codes 0x unconnected; 10 clear up/set down; 11 inverse.
// - Modulator compare writes buffer until 255; reads give buffer.
// - Modulator overflow sets on leaving zero; flags otherwise same.
module tmr2_timer #(
  parameter int PRE_WIDTH = tmr2_pkg::PRE_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  output logic overflow_req_out,
  output logic compare_req_out,
  output logic port_d_bit_seven_pin_out,
  output logic port_d_bit_seven_pin_oe_out
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] compare_buf_reg;
  logic [7:0] compare_act_reg;
  logic [1:0] irq_flags_reg;
  logic [1:0] irq_mask_reg;
  logic port_latch_reg;
  logic port_dir_reg;
  logic [7:0] rdata_reg;
  logic down_reg;
  logic counted_reg;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic modulator_enable;
  logic [1:0] compare_out_mode;
  logic clear_on_match;
  logic [2:0] clock_sel;
  logic timer_tick;
  logic match;
  logic overflow_event;
  logic wr_control;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_mask;
  logic wr_port;
  logic oc_level;
  logic pin_connected;

  // Register field views
  assign modulator_enable = control_reg[tmr2_pkg::CTRL_MODULATOR_BIT];
  assign compare_out_mode = {control_reg[tmr2_pkg::CTRL_MODE_HI_BIT],
                             control_reg[tmr2_pkg::CTRL_MODE_LO_BIT]};
  assign clear_on_match = control_reg[tmr2_pkg::CTRL_CLEAR_BIT];
  assign clock_sel = control_reg[tmr2_pkg::CTRL_SEL_HI_BIT:
                                 tmr2_pkg::CTRL_SEL_LO_BIT];

  // Write strobes per register
  assign wr_control = write_in && addr_in == tmr2_pkg::ADDR_CONTROL;
  assign wr_count = write_in && addr_in == tmr2_pkg::ADDR_COUNT;
  assign wr_compare = write_in && addr_in == tmr2_pkg::ADDR_COMPARE;
  assign wr_flags = write_in && addr_in == tmr2_pkg::ADDR_IRQ_FLAGS;
  assign wr_mask = write_in && addr_in == tmr2_pkg::ADDR_IRQ_MASK;
  assign wr_port = write_in && addr_in == tmr2_pkg::ADDR_PORT_CTRL;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  tmr2_prescaler #(
    .WIDTH(PRE_WIDTH)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clock_sel_in(clock_sel),
    .tick_out(timer_tick)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reserved top bit is never stored
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_reg <= tmr2_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control_reg <= wdata_in & tmr2_pkg::CONTROL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  // A match needs the counter to have counted into the value
  assign match = counted_reg &&
                 count_reg == compare_act_reg;

  // Overflow: wrap in normal mode, leaving zero in modulator mode
  always_comb begin
    overflow_event = 1'b0;
    if (timer_tick && !wr_count) begin
      if (modulator_enable) begin
        overflow_event = count_reg == tmr2_pkg::COUNT_BOTTOM &&
                         (down_reg || counted_reg == 1'b0);
      end else begin
        overflow_event = count_reg == tmr2_pkg::COUNT_TOP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Next count value; a software write takes priority
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = wdata_in;
    end else if (match && clear_on_match && !modulator_enable) begin
      count_next = tmr2_pkg::COUNT_BOTTOM;
    end else if (timer_tick) begin
      if (!modulator_enable) begin
        count_next = count_reg + 8'h01;
      end else if (!down_reg && count_reg == tmr2_pkg::COUNT_TOP) begin
        count_next = count_reg - 8'h01;
      end else if (down_reg && count_reg == tmr2_pkg::COUNT_BOTTOM) begin
        count_next = count_reg + 8'h01;
      end else if (down_reg) begin
        count_next = count_reg - 8'h01;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  // Count register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= tmr2_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Marks that the current value was reached by counting
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counted_reg <= 1'b0;
    end else if (wr_count) begin
      counted_reg <= 1'b0;
    end else if (timer_tick) begin
      counted_reg <= 1'b1;
    end else if (wr_compare && !modulator_enable) begin
      counted_reg <= 1'b0;
    end else if (match) begin
      counted_reg <= 1'b0; // One match per value reached
    end
  end

  // Direction of the modulator count; turns at top and bottom
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      down_reg <= 1'b0;
    end else if (!modulator_enable) begin
      down_reg <= 1'b0;
    end else if (timer_tick && !wr_count) begin
      if (count_reg == tmr2_pkg::COUNT_TOP) begin
        down_reg <= 1'b1;
      end else if (count_reg == tmr2_pkg::COUNT_BOTTOM) begin
        down_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare register with modulator holding buffer
  // ----------------------------------------------------------------
  // Software view: always the most recently written value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_buf_reg <= tmr2_pkg::COMPARE_RESET;
    end else if (wr_compare) begin
      compare_buf_reg <= wdata_in;
    end
  end

  // Active value: direct in normal mode, latched at top when modulating
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_act_reg <= tmr2_pkg::COMPARE_RESET;
    end else if (!modulator_enable) begin
      if (wr_compare) begin
        compare_act_reg <= wdata_in;
      end else begin
        compare_act_reg <= compare_buf_reg;
      end
    end else if (count_reg == tmr2_pkg::COUNT_TOP && counted_reg) begin
      compare_act_reg <= compare_buf_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt flags and mask
  // ----------------------------------------------------------------
  // Flags set the cycle after the event; writing one clears; set wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_flags_reg <= 2'b00;
    end else begin
      if (overflow_event) begin
        irq_flags_reg[tmr2_pkg::IRQ_OVERFLOW_BIT] <= 1'b1;
      end else if (wr_flags && wdata_in[tmr2_pkg::IRQ_OVERFLOW_BIT]) begin
        irq_flags_reg[tmr2_pkg::IRQ_OVERFLOW_BIT] <= 1'b0;
      end
      if (match) begin
        irq_flags_reg[tmr2_pkg::IRQ_COMPARE_BIT] <= 1'b1;
      end else if (wr_flags && wdata_in[tmr2_pkg::IRQ_COMPARE_BIT]) begin
        irq_flags_reg[tmr2_pkg::IRQ_COMPARE_BIT] <= 1'b0;
      end
    end
  end

  // Mask register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= 2'b00;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata_in[1:0];
    end
  end

  // Requests gated by the mask
  assign overflow_req_out = irq_flags_reg[tmr2_pkg::IRQ_OVERFLOW_BIT] &&
                            irq_mask_reg[tmr2_pkg::IRQ_OVERFLOW_BIT];
  assign compare_req_out = irq_flags_reg[tmr2_pkg::IRQ_COMPARE_BIT] &&
                           irq_mask_reg[tmr2_pkg::IRQ_COMPARE_BIT];

  // ----------------------------------------------------------------
  // Compare output and shared pin
  // ----------------------------------------------------------------
  tmr2_compare_out u_compare_out (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .mode_in(compare_out_mode),
    .modulator_in(modulator_enable),
    .match_in(match),
    .down_in(down_reg),
    .compare_in(compare_act_reg),
    .level_out(oc_level)
  );

  // Port latch and direction bit of the shared pin
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_latch_reg <= 1'b0;
      port_dir_reg <= 1'b0;
    end else if (wr_port) begin
      port_latch_reg <= wdata_in[tmr2_pkg::PORT_LATCH_BIT];
      port_dir_reg <= wdata_in[tmr2_pkg::PORT_DIR_BIT];
    end
  end

  // Codes 0x leave the pin to the port in modulator mode
  assign pin_connected = modulator_enable ? compare_out_mode[1] :
                         compare_out_mode != tmr2_pkg::MODE_OFF;

  // Pin driven only with direction set to output
  assign port_d_bit_seven_pin_oe_out = port_dir_reg;
  assign port_d_bit_seven_pin_out = pin_connected ? oc_level :
                                    port_latch_reg;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data stand the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else if (read_in) begin
      case (addr_in)
        tmr2_pkg::ADDR_CONTROL: rdata_reg <= control_reg;
        tmr2_pkg::ADDR_COUNT: rdata_reg <= count_reg;
        tmr2_pkg::ADDR_COMPARE: rdata_reg <= compare_buf_reg;
        tmr2_pkg::ADDR_IRQ_FLAGS: rdata_reg <= {6'h00, irq_flags_reg};
        tmr2_pkg::ADDR_IRQ_MASK: rdata_reg <= {6'h00, irq_mask_reg};
        tmr2_pkg::ADDR_PORT_CTRL: rdata_reg <= {6'h00, port_dir_reg,
                                                port_latch_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_out = rdata_reg;
endmodule // tmr2_timer

// ==== verification/tmr2_timer_checker.sv ====
// Port checks of the 8-bit timer with compare and modulator
`timescale 1ns/1ps
module tmr2_timer_checker #(
  parameter int PRE_WIDTH = tmr2_pkg::PRE_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic overflow_req_out,
  input wire logic compare_req_out,
  input wire logic port_d_bit_seven_pin_out,
  input wire logic port_d_bit_seven_pin_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  logic [7:0] ctrl_sh_reg;
  logic [1:0] mask_sh_reg;
  logic [2:0] stop_cnt_reg;
  logic wc, wm, wn, wo, wp, rc, rn, ro, stopped;

  // Decoded strobes
  assign wc = write_in && (addr_in == tmr2_pkg::ADDR_CONTROL);
  assign wm = write_in && (addr_in == tmr2_pkg::ADDR_IRQ_MASK);
  assign wn = write_in && (addr_in == tmr2_pkg::ADDR_COUNT);
  assign wo = write_in && (addr_in == tmr2_pkg::ADDR_COMPARE);
  assign wp = write_in && (addr_in == tmr2_pkg::ADDR_PORT_CTRL);
  assign rc = read_in && (addr_in == tmr2_pkg::ADDR_CONTROL);
  assign rn = read_in && (addr_in == tmr2_pkg::ADDR_COUNT);
  assign ro = read_in && (addr_in == tmr2_pkg::ADDR_COMPARE);
  assign stopped = (stop_cnt_reg == 3'h7);

  // Shadow of control and mask as software wrote them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_sh_reg <= 8'h00;
      mask_sh_reg <= 2'h0;
    end else begin
      if (wc) ctrl_sh_reg <= wdata_in;
      if (wm) mask_sh_reg <= wdata_in[1:0];
    end
  end

  // Settled stop: seven cycles with no control write and select zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_cnt_reg <= 3'h0;
    end else if (wc || (ctrl_sh_reg[2:0] != 3'h0)) begin
      stop_cnt_reg <= 3'h0;
    end else if (!stopped) begin
      stop_cnt_reg <= stop_cnt_reg + 3'h1;
    end
  end

  a_ctrl_top_zero: assert property (rc |=> !rdata_out[7])
    else $error("control bit 7 read as one");
  a_ctrl_read_back: assert property (wc ##1 rc |=>
    rdata_out == ($past(wdata_in, 2) & tmr2_pkg::CONTROL_WMASK))
    else $error("control read back wrong");
  a_cmp_read_back: assert property (wo ##1 ro |=>
    rdata_out == $past(wdata_in, 2))
    else $error("compare read back wrong");
  a_cnt_read_back: assert property ((wn && stopped) ##1 rn |=>
    rdata_out == $past(wdata_in, 2))
    else $error("count read back wrong");
  a_oe_follows_dir: assert property (wp |=>
    port_d_bit_seven_pin_oe_out == $past(wdata_in[1]))
    else $error("pin enable not equal to direction bit");
  a_ovf_req_masked: assert property (overflow_req_out |->
    mask_sh_reg[0] || $past(mask_sh_reg[0]))
    else $error("overflow request while masked");
  a_cmp_req_masked: assert property (compare_req_out |->
    mask_sh_reg[1] || $past(mask_sh_reg[1]))
    else $error("compare request while masked");
  a_ovf_stop_quiet: assert property ($rose(overflow_req_out) &&
    $past(mask_sh_reg[0]) |-> !stopped)
    else $error("overflow while stopped");
  a_cmp_stop_quiet: assert property ($rose(compare_req_out) &&
    $past(mask_sh_reg[1]) |-> !stopped)
    else $error("compare match while stopped");
  a_latch_no_preset: assert property (wp && stopped &&
    !ctrl_sh_reg[6] && (ctrl_sh_reg[5:4] != 2'h0)
    |=> $stable(port_d_bit_seven_pin_out))
    else $error("latch write moved the compare output");

  c_cmp_req: cover property ($rose(compare_req_out));
  c_ovf_req: cover property ($rose(overflow_req_out));
  c_pin_rise: cover property ($rose(port_d_bit_seven_pin_out));
  c_oe_rise: cover property ($rose(port_d_bit_seven_pin_oe_out));
endmodule // tmr2_timer_checker

bind tmr2_timer tmr2_timer_checker #(.PRE_WIDTH(PRE_WIDTH)) u_checker (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .write_in(write_in),
  .read_in(read_in),
  .rdata_out(rdata_out),
  .overflow_req_out(overflow_req_out),
  .compare_req_out(compare_req_out),
  .port_d_bit_seven_pin_out(port_d_bit_seven_pin_out),
  .port_d_bit_seven_pin_oe_out(port_d_bit_seven_pin_oe_out)
);

// ==== verification/tmr2_timer_tb.sv ====
// Self-checking bench of the 8-bit timer with compare and modulator
`timescale 1ns/1ps
module tmr2_timer_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [7:0] rdata_out;
  logic ovf_req, cmp_req, pin, pin_oe;
  logic [7:0] rv;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int hi, lo, c, n;
  int div_q[$] = '{1, 8, 32, 64, 128, 256, 1024};

  // Clock and hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 40000) begin
      mismatches++;
      results();
    end
  end

  tmr2_timer u_dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .overflow_req_out(ovf_req),
    .compare_req_out(cmp_req),
    .port_d_bit_seven_pin_out(pin),
    .port_d_bit_seven_pin_oe_out(pin_oe)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  // Write then read back with no gap
  task automatic wrrd(input logic [7:0] a, input logic [7:0] v,
                      output logic [7:0] r);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1 r = rdata_out;
  endtask

  // Cycles until the pin shows a level
  task automatic wait_lvl(input logic lvl, output int k);
    k = 0;
    while (pin !== lvl && k < 3000) begin
      @(posedge clk_in);
      #1 k++;
    end
  endtask

  // High and low widths of one full pin period
  task automatic measure();
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(48));
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int a = 8'h23; a <= 8'h39; a++) begin
      rd(8'(a), rv);
      check(rv, 8'h00);
    end
    wrrd(8'h00, 8'ha5, rv);
    check(rv, 8'h00);
    wrrd(tmr2_pkg::ADDR_CONTROL, 8'hff, rv);
    check(rv, 8'h7f);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h00);
    $display("test reset and control done");
    // Every clock select divides as listed
    foreach (div_q[i]) begin
      wr(tmr2_pkg::ADDR_COUNT, 8'h00);
      wr(tmr2_pkg::ADDR_CONTROL, 8'(i + 1));
      repeat (8 * div_q[i]) @(posedge clk_in);
      rd(tmr2_pkg::ADDR_COUNT, rv);
      wr(tmr2_pkg::ADDR_CONTROL, 8'h00);
      check(16'(rv >= 8'd7 && rv <= 8'd10), 16'h0001);
    end
    repeat (10) @(posedge clk_in);
    wrrd(tmr2_pkg::ADDR_COUNT, 8'h5a, rv);
    check(rv, 8'h5a);
    repeat (50) @(posedge clk_in);
    rd(tmr2_pkg::ADDR_COUNT, rv);
    check(rv, 8'h5a);
    $display("test clock select done");
    // A written equality is no match, from either register
    wr(tmr2_pkg::ADDR_COMPARE, 8'h10);
    wr(tmr2_pkg::ADDR_IRQ_MASK, 8'h03);
    wr(tmr2_pkg::ADDR_COUNT, 8'h3e);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h01);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h00);
    rd(tmr2_pkg::ADDR_COUNT, rv);
    check(rv, 8'h40);
    wr(tmr2_pkg::ADDR_IRQ_FLAGS, 8'h03);
    wr(tmr2_pkg::ADDR_COMPARE, 8'h40);
    wr(tmr2_pkg::ADDR_COUNT, 8'h40);
    repeat (5) @(posedge clk_in);
    rd(tmr2_pkg::ADDR_IRQ_FLAGS, rv);
    check(rv[1], 1'b0);
    check(cmp_req, 1'b0);
    // Toggle with clear on match, then free running
    c = 20 + ($urandom % 180);
    wr(tmr2_pkg::ADDR_COMPARE, 8'(c));
    wr(tmr2_pkg::ADDR_PORT_CTRL, 8'h02);
    check(pin_oe, 1'b1);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h19);
    measure();
    check(16'(hi), 16'(c + 1));
    check(16'(lo), 16'(c + 1));
    check(cmp_req, 1'b1);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h11);
    measure();
    check(16'(hi), 16'h0100);
    check(ovf_req, 1'b1);
    wr(tmr2_pkg::ADDR_IRQ_MASK, 8'h01);
    check(cmp_req, 1'b0);
    rd(tmr2_pkg::ADDR_IRQ_FLAGS, rv);
    check(rv[1], 1'b1);
    $display("test compare match done");
    // Set and clear codes, then latch writes while stopped
    for (int m = 0; m < 2; m++) begin
      wr(tmr2_pkg::ADDR_CONTROL, 8'h31 - 8'(m * 16));
      repeat (300) @(posedge clk_in);
      #1;
      check(pin, 1'(m == 0));
      wr(tmr2_pkg::ADDR_CONTROL, 8'h30 - 8'(m * 16));
      repeat (8) @(posedge clk_in);
      wr(tmr2_pkg::ADDR_PORT_CTRL, 8'h02 | 8'(m));
      check(pin, 1'(m == 0));
    end
    wr(tmr2_pkg::ADDR_CONTROL, 8'h00);
    check(pin, 1'b1);
    wr(tmr2_pkg::ADDR_IRQ_FLAGS, 8'h03);
    rd(tmr2_pkg::ADDR_IRQ_FLAGS, rv);
    check(rv, 8'h00);
    check(ovf_req, 1'b0);
    $display("test output codes done");
    // Modulator with clear bit set, both polarities, buffered compare
    c = 20 + ($urandom % 180);
    wr(tmr2_pkg::ADDR_COMPARE, 8'(c));
    wr(tmr2_pkg::ADDR_PORT_CTRL, 8'h02);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h69);
    measure();
    check(16'(lo), 16'(2 * (255 - c)));
    check(16'(hi + lo), 16'd510);
    wr(tmr2_pkg::ADDR_CONTROL, 8'h79);
    measure();
    check(16'(hi), 16'(2 * (255 - c)));
    wrrd(tmr2_pkg::ADDR_COMPARE, 8'(c + 30), rv);
    check(rv, 8'(c + 30));
    measure();
    measure();
    check(16'(hi), 16'(2 * (225 - c)));
    wr(tmr2_pkg::ADDR_IRQ_FLAGS, 8'h03);
    repeat (520) @(posedge clk_in);
    rd(tmr2_pkg::ADDR_IRQ_FLAGS, rv);
    check(rv[0], 1'b1);
    $display("test modulator done");
    results();
  end
endmodule // tmr2_timer_tb
